// ---- hdl/dpll_pbo_regs.svh ----
// register offsets, field positions, reset values and timing counts for the build-out control block
`ifndef DPLL_REBUILD_REGS_SVH
`define DPLL_REBUILD_REGS_SVH
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_OFFSET    8'h08
`define OFS_REF_EN    8'h0C
`define CTRL_MODE_LO  0
`define CTRL_BWL_LO   4
`define CTRL_BWA_LO   8
`define MODE_ENABLED  2'h0
`define MODE_DISABLED 2'h1
`define MODE_FROZEN   2'h2
`define BW_STEPS      10
`define BW_LOCK_RST   4'h2
`define BW_ACQ_RST    4'h7
`define REF_EN_RST    32'hFFFF_FFFF
`define CLK_PERIOD_NS 100
`define MEAS_TIME_NS  1600
`define TRANSIENT_NS  5
`define PS_PER_NS     1000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ---- hdl/dpll_pbo_pkg.sv ----
// types shared by the build-out control block
package dpll_rebuild_pkg;
	typedef enum logic [1:0] {ST_SEARCH, ST_TRACK, ST_HOLD} sel_state_t;
	typedef logic [3:0] bw_idx_t;
	typedef logic [1:0] rebuild_mode_t;
endpackage

// ---- hdl/dpll_phase_buildout_switch.sv ----
// reference switchover, phase offset rebuild and bandwidth control around the timing dpll
// Summary of operation
// [R1] bandwidth follows lock state without software
// [R2] lock indication picks acquisition or normal bandwidth
// [R3] ten programmable bandwidth steps, index 0 to 9
// [R4] lost reference: pick next priority, raise event
// [R5] event enters temporary holdover, output keeps running
// [R6] measure new phase, inject matching offset
// [R7] residual phase step clamped to 5 ns
// [R8] software selects enabled, disabled or frozen
// [R9] rebuild enabled after reset
// [R10] freeze only from enabled; offset retained
// [R11] frozen: later events add no offset
// [R12] disabled: switch without measuring or offset
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dpll_pbo_regs.svh"
module dpll_phase_buildout_switch
	import dpll_rebuild_pkg::*;
#(
	parameter int NREF = 14,
	parameter int PW   = 24
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [NREF-1:0]        ref_ok,
	input  wire logic                   phase_locked,
	input  wire logic signed [PW-1:0]   phase_err,
	output logic [3:0]                  ref_sel,
	output logic                        ref_none,
	output logic                        holdover,
	output bw_idx_t                     bw_sel,
	output logic                        rebuild_event,
	output logic signed [PW-1:0]        phase_offset,
	output logic signed [PW-1:0]        phase_corr
);
	// derived counts; measurement window rounds up to whole cycles
	localparam int MEAS_CYC = (`MEAS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam logic signed [PW-1:0] LIM = PW'(`TRANSIENT_NS * `PS_PER_NS);

	// refuse sizes the select field and phase math cannot serve
	if (NREF < 2 || NREF > 16 || PW < 16 || PW > 32) begin : g_bad_size
		$error("unsupported NREF or PW");
	end

	// software state
	rebuild_mode_t    mode_r;        // rebuild mode
	bw_idx_t          bwl_r;         // locked bandwidth step
	bw_idx_t          bwa_r;         // acquisition bandwidth step
	logic [NREF-1:0]  ref_en_r;      // per-reference enable
	// pin synchronisers, three stages
	logic [NREF-1:0]  s1_r, s2_r, s3_r;
	logic [NREF-1:0]  ok_r;          // filtered reference health
	// selection state
	sel_state_t       st_r;
	logic [7:0]       meas_r;        // holdover measurement counter
	logic [NREF-1:0]  avail;
	logic [3:0]       best;
	logic             any_avail;

	// pins pass three flops; first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= ref_ok;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NREF; gi++) begin : g_ok
			always_ff @(posedge aclk) begin
				if (!aresetn)
					ok_r[gi] <= 1'b0;
				else if (s2_r[gi] == s3_r[gi])
					ok_r[gi] <= s3_r[gi];
			end
		end
	endgenerate

	// lowest index wins: index 0 is the highest priority
	always_comb begin
		avail = ok_r & ref_en_r;
		any_avail = 1'b0;
		best = 4'h0;
		for (int i = NREF - 1; i >= 0; i--) begin
			if (avail[i]) begin
				best = 4'(i);
				any_avail = 1'b1;
			end
		end
	end

	// selection, temporary holdover and offset rebuild
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_SEARCH;
			ref_sel <= 4'h0;
			ref_none <= 1'b1;
			holdover <= 1'b0;
			rebuild_event <= 1'b0;
			meas_r <= 8'h00;
			phase_offset <= '0;
		end else begin
			rebuild_event <= 1'b0;
			// disabled: no offset kept, dpll locks to raw input phase
			if (mode_r == `MODE_DISABLED)
				phase_offset <= '0; // R12
			case (st_r)
				ST_SEARCH: begin
					// first pick after nothing was usable: no switch event
					if (any_avail) begin
						ref_sel <= best;
						ref_none <= 1'b0;
						st_r <= ST_TRACK;
					end
				end
				ST_TRACK: begin
					if (!avail[ref_sel]) begin
						if (any_avail) begin
							ref_sel <= best; // R4
							rebuild_event <= 1'b1; // R4
							// only an enabled rebuild measures; frozen ignores the event
							if (mode_r == `MODE_ENABLED) begin // R11
								holdover <= 1'b1; // R5
								meas_r <= 8'(MEAS_CYC);
								st_r <= ST_HOLD;
							end
						end else begin
							// nothing left: long-term holdover belongs to the dpll
							ref_none <= 1'b1;
							st_r <= ST_SEARCH;
						end
					end
				end
				ST_HOLD: begin
					// output runs from last frequency while the new input settles
					if (meas_r > 8'h01) begin
						meas_r <= meas_r - 8'h01;
					end else begin
						// measured error becomes the offset so the residual is near zero
						if (mode_r == `MODE_ENABLED)
							phase_offset <= phase_err; // R6
						holdover <= 1'b0;
						meas_r <= 8'h00;
						st_r <= ST_TRACK;
					end
				end
				default: st_r <= ST_SEARCH;
			endcase
		end
	end

	// corrected error to the loop filter; clamp bounds any leftover step
	always_ff @(posedge aclk) begin
		if (!aresetn)
			phase_corr <= '0;
		else if (holdover)
			phase_corr <= '0;
		else if (phase_err - phase_offset > LIM)
			phase_corr <= LIM; // R7
		else if (phase_err - phase_offset < -LIM)
			phase_corr <= -LIM; // R7
		else
			phase_corr <= phase_err - phase_offset;
	end

	// bandwidth: acquisition while unlocked, normal once locked
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bw_sel <= `BW_ACQ_RST;
		else if (!holdover)
			bw_sel <= phase_locked ? bwl_r : bwa_r; // R1 R2
	end

	// axi4-lite write side: address and data taken in either order
	logic [7:0]  aw_r;
	logic [31:0] wd_r;
	logic [3:0]  ws_r;
	logic        aw_ok, w_ok;
	logic        do_wr;
	assign do_wr = aw_ok && w_ok && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_ok && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_ok && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if ({aw_r[7:2], 2'b00} == `OFS_CTRL || {aw_r[7:2], 2'b00} == `OFS_REF_EN)
					s_axi_bresp <= `RESP_OKAY;
				else if ({aw_r[7:2], 2'b00} == `OFS_STATUS || {aw_r[7:2], 2'b00} == `OFS_OFFSET)
					s_axi_bresp <= `RESP_OKAY;
				else
					s_axi_bresp <= `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers; read-only words ignore writes
	logic [3:0] wbwl, wbwa;
	assign wbwl = wd_r[`CTRL_BWL_LO +: 4];
	assign wbwa = wd_r[`CTRL_BWA_LO +: 4];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= `MODE_ENABLED; // R9
			bwl_r <= `BW_LOCK_RST;
			bwa_r <= `BW_ACQ_RST;
			ref_en_r <= NREF'(`REF_EN_RST);
		end else if (do_wr && {aw_r[7:2], 2'b00} == `OFS_CTRL) begin
			// freeze accepted only from enabled; reserved code 3 ignored
			if (ws_r[0] && wd_r[1:0] != 2'h3) begin
				if (!(wd_r[1:0] == `MODE_FROZEN && mode_r == `MODE_DISABLED))
					mode_r <= wd_r[1:0]; // R8 R10
			end
			// steps saturate at the last of the ten settings
			if (ws_r[0])
				bwl_r <= (wbwl > 4'd9) ? 4'd9 : wbwl; // R3
			if (ws_r[1])
				bwa_r <= (wbwa > 4'd9) ? 4'd9 : wbwa; // R3
		end else if (do_wr && {aw_r[7:2], 2'b00} == `OFS_REF_EN) begin
			for (int b = 0; b < NREF; b++)
				if (ws_r[b / 8])
					ref_en_r[b] <= wd_r[b];
		end
	end

	// axi4-lite read side: one cycle to arready, rdata next
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				if ({s_axi_araddr[7:2], 2'b00} == `OFS_CTRL)
					s_axi_rdata <= {20'h0_0000, bwa_r, bwl_r, 2'b00, mode_r};
				else if ({s_axi_araddr[7:2], 2'b00} == `OFS_STATUS)
					s_axi_rdata <= {16'h0000, bw_sel, ref_sel, 4'h0, ref_none, phase_locked, holdover,
						st_r == ST_HOLD};
				else if ({s_axi_araddr[7:2], 2'b00} == `OFS_OFFSET)
					s_axi_rdata <= 32'(phase_offset);
				else if ({s_axi_araddr[7:2], 2'b00} == `OFS_REF_EN)
					s_axi_rdata <= 32'(ref_en_r);
				else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	property p_bw_follow;
		@(posedge aclk) disable iff (!aresetn)
		!holdover && phase_locked |=> bw_sel == $past(bwl_r);
	endproperty
	a_bw_follow: assert property (p_bw_follow) else $error("locked bandwidth not applied"); // R2

	property p_bw_range;
		@(posedge aclk) disable iff (!aresetn) bw_sel < 4'd10;
	endproperty
	a_bw_range: assert property (p_bw_range) else $error("bandwidth step out of range"); // R3

	property p_reset_mode;
		@(posedge aclk) !aresetn |=> mode_r == `MODE_ENABLED;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("rebuild not enabled after reset"); // R9

	property p_switch;
		@(posedge aclk) disable iff (!aresetn)
		st_r == ST_TRACK && !avail[ref_sel] && any_avail |=> rebuild_event && ref_sel == $past(best);
	endproperty
	a_switch: assert property (p_switch) else $error("lost reference not replaced"); // R4

	property p_enter_hold;
		@(posedge aclk) disable iff (!aresetn)
		rebuild_event && $past(mode_r) == `MODE_ENABLED |-> holdover;
	endproperty
	a_enter_hold: assert property (p_enter_hold) else $error("no temporary holdover on event"); // R5

	property p_hold_len;
		@(posedge aclk) disable iff (!aresetn)
		$rose(holdover) |-> holdover [*8] ##1 holdover [*8] ##1 !holdover;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("holdover length wrong"); // R6

	property p_clamp;
		@(posedge aclk) disable iff (!aresetn) phase_corr <= LIM && phase_corr >= -LIM;
	endproperty
	a_clamp: assert property (p_clamp) else $error("phase step exceeds bound"); // R7

	property p_frozen;
		@(posedge aclk) disable iff (!aresetn)
		mode_r == `MODE_FROZEN ##1 mode_r == `MODE_FROZEN |-> $stable(phase_offset) && !$rose(holdover);
	endproperty
	a_frozen: assert property (p_frozen) else $error("offset moved while frozen"); // R11

	property p_no_freeze_from_off;
		@(posedge aclk) disable iff (!aresetn)
		$past(mode_r) == `MODE_DISABLED |-> mode_r != `MODE_FROZEN;
	endproperty
	a_no_freeze_from_off: assert property (p_no_freeze_from_off) else $error("froze from disabled"); // R10

	property p_disabled;
		@(posedge aclk) disable iff (!aresetn)
		mode_r == `MODE_DISABLED |=> phase_offset == '0;
	endproperty
	a_disabled: assert property (p_disabled) else $error("offset kept while disabled"); // R12
endmodule

// ---- sim/ref_src_model.sv ----
// reference sources and dpll stand-in feeding the build-out control block
`timescale 1ns/100ps
module ref_src_model #(
	parameter int NREF = 14,
	parameter int PW   = 24
) (
	input  wire logic [NREF-1:0]      lost,
	input  wire logic                 lock_req,
	input  wire logic signed [PW-1:0] phase_req,
	output logic [NREF-1:0]           ref_ok,
	output logic                      phase_locked,
	output logic signed [PW-1:0]      phase_err
);
	// health pins are levels; a lost source simply reads unusable
	assign ref_ok       = ~lost;
	// lock indication is what picks the loop bandwidth inside the block
	assign phase_locked = lock_req;
	// new source minus output phase in ps, held steady so offsets are exact
	assign phase_err    = phase_req;
endmodule

// ---- sim/dpll_phase_buildout_switch_tb.sv ----
// self-checking bench for the build-out control block
`timescale 1ns/100ps
`include "dpll_pbo_regs.svh"
module dpll_phase_buildout_switch_tb;
	localparam int NREF     = 14;
	localparam int PW       = 24;
	localparam int MEAS_CYC = 16; // holdover length in cycles
	// one row: optional write, then a read with its expected answer
	typedef struct packed {
		logic        wr;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [1:0]  wresp;
		logic [7:0]  ra;
		logic [31:0] rexp;
		logic [1:0]  rresp;
	} row_t;
	logic                 aclk;                    // system clock
	logic                 aresetn;                 // sync reset, low active
	logic [7:0]           awaddr;                  // write address
	logic [7:0]           araddr;                  // read address
	logic                 awvalid, wvalid, arvalid; // master requests
	logic                 bready, rready;          // kept high: answers always taken
	logic                 awready, wready, arready; // slave accepts
	logic                 bvalid, rvalid;          // slave answers
	logic [31:0]          wdata, rdata;            // data words
	logic [3:0]           wstrb;                   // full word writes only
	logic [1:0]           bresp, rresp;            // response codes
	logic [NREF-1:0]      lost;                    // sources the bench has killed
	logic                 lock_req;                // lock state to present
	logic signed [PW-1:0] phase_req;               // phase error to present
	logic [NREF-1:0]      ref_ok;
	logic                 phase_locked;
	logic signed [PW-1:0] phase_err;
	logic [3:0]           ref_sel;
	logic                 ref_none, holdover, rebuild_event;
	logic [3:0]           bw_sel;
	logic signed [PW-1:0] phase_offset, phase_corr;
	int                   mismatches, checked, n;  // tallies and a wait counter
	logic [31:0]          rd;                      // last read data
	logic [1:0]           resp;                    // last response
	row_t                 rows [9];                // ordinary register cases

	dpll_phase_buildout_switch #(.NREF(NREF), .PW(PW)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ref_ok(ref_ok), .phase_locked(phase_locked), .phase_err(phase_err),
		.ref_sel(ref_sel), .ref_none(ref_none), .holdover(holdover), .bw_sel(bw_sel),
		.rebuild_event(rebuild_event), .phase_offset(phase_offset), .phase_corr(phase_corr)
	);

	ref_src_model #(.NREF(NREF), .PW(PW)) i_src (
		.lost(lost), .lock_req(lock_req), .phase_req(phase_req),
		.ref_ok(ref_ok), .phase_locked(phase_locked), .phase_err(phase_err)
	);

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// compare and tally
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
	endtask

	// read: address held until taken, data taken at the rvalid edge
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	// kill one source, wait for the switch strobe, check new pick and holdover entry
	task automatic drop_ref(input int idx, input logic [3:0] nsel, input logic hold_exp);
		int k;
		lost[idx] <= 1'b1;
		k = 0;
		do begin @(posedge aclk); k++; end while (rebuild_event !== 1'b1 && k < 12);
		check(32'(rebuild_event), 32'h0000_0001);
		check(32'(ref_sel), 32'(nsel));
		check(32'(holdover), 32'(hold_exp));
		@(posedge aclk);
		check(32'(rebuild_event), 32'h0000_0000);
	endtask

	// hang guard: the whole run needs far fewer cycles
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		complete_run;
	end

	// main sequence
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, awvalid, wvalid, arvalid, wdata} = '0;
		{bready, rready, wstrb} = 6'h3F;
		lost = '0;
		lock_req = 1'b0;
		phase_req = '0;
		rows[0] = '{1'b0, 8'h00, 32'h0, 2'h0, `OFS_CTRL,
			{20'h0_0000, `BW_ACQ_RST, `BW_LOCK_RST, 2'h0, `MODE_ENABLED}, `RESP_OKAY};
		rows[1] = '{1'b0, 8'h00, 32'h0, 2'h0, `OFS_REF_EN, {{(32-NREF){1'b0}}, {NREF{1'b1}}}, `RESP_OKAY};
		rows[2] = '{1'b0, 8'h00, 32'h0, 2'h0, `OFS_OFFSET, 32'h0000_0000, `RESP_OKAY};
		rows[3] = '{1'b1, `OFS_CTRL, 32'h0000_0FF0, `RESP_OKAY, `OFS_CTRL, 32'h0000_0990, `RESP_OKAY};
		rows[4] = '{1'b1, `OFS_OFFSET, 32'h1234_5678, `RESP_OKAY, `OFS_OFFSET, 32'h0000_0000, `RESP_OKAY};
		rows[5] = '{1'b1, 8'h10, 32'hFFFF_FFFF, `RESP_SLVERR, 8'h10, 32'h0000_0000, `RESP_SLVERR};
		rows[6] = '{1'b1, `OFS_CTRL, 32'h0000_0720, `RESP_OKAY, `OFS_CTRL, 32'h0000_0720, `RESP_OKAY};
		// status ignores writes; unlocked, tracking source 0, acquisition step in use
		rows[7] = '{1'b1, `OFS_STATUS, 32'hFFFF_FFFF, `RESP_OKAY, `OFS_STATUS,
			{16'h0000, `BW_ACQ_RST, 12'h000}, `RESP_OKAY};
		// masking the lowest priority source leaves the current pick alone
		rows[8] = '{1'b1, `OFS_REF_EN, 32'h0000_1FFF, `RESP_OKAY, `OFS_REF_EN, 32'h0000_1FFF, `RESP_OKAY};
		repeat (4) @(posedge aclk);
		// reset state
		check(32'(ref_none), 32'h0000_0001);
		check(32'(bw_sel), 32'(`BW_ACQ_RST));
		check(32'(phase_offset), 32'h0000_0000);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		check(32'(ref_sel), 32'h0000_0000);
		check(32'(ref_none), 32'h0000_0000);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].wa, rows[i].wd, resp);
				check(32'(resp), 32'(rows[i].wresp));
			end
			axi_read(rows[i].ra, rd, resp);
			check(rd, rows[i].rexp);
			check(32'(resp), 32'(rows[i].rresp));
		end
		// unlocked loop runs wide, locked loop narrows without software
		check(32'(bw_sel), 32'(`BW_ACQ_RST));
		lock_req <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (bw_sel !== `BW_LOCK_RST && n < 8);
		check(32'(bw_sel), 32'(`BW_LOCK_RST));
		// enabled: 3000 ps measured in holdover becomes the offset
		phase_req <= 24'h00_0BB8;
		drop_ref(0, 4'h1, 1'b1);
		n = 0;
		while (holdover === 1'b1 && n < 40) begin @(posedge aclk); n++; end
		check(32'(n), 32'(MEAS_CYC - 1));
		check(32'(phase_offset), 32'h0000_0BB8);
		@(posedge aclk);
		check(32'(phase_corr), 32'h0000_0000);
		// big input steps: residual correction saturates both ways
		phase_req <= 24'h00_2EE0;
		repeat (2) @(posedge aclk);
		check(32'(phase_corr), 32'h0000_1388);
		phase_req <= 24'hFF_BD98;
		repeat (2) @(posedge aclk);
		check(32'(phase_corr), 32'hFFFF_EC78);
		// frozen: switch still happens, offset kept, no holdover
		axi_write(`OFS_CTRL, 32'h0000_0722, resp);
		drop_ref(1, 4'h2, 1'b0);
		check(32'(phase_offset), 32'h0000_0BB8);
		// disabled: a freeze request is ignored, switch carries no offset
		axi_write(`OFS_CTRL, 32'h0000_0721, resp);
		axi_write(`OFS_CTRL, 32'h0000_0722, resp);
		axi_read(`OFS_CTRL, rd, resp);
		check(rd, 32'h0000_0721);
		drop_ref(2, 4'h3, 1'b0);
		check(32'(phase_offset), 32'h0000_0000);
		// mid-run reset: rebuild back to enabled, register defaults restored
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		check(32'(ref_none), 32'h0000_0001);
		aresetn <= 1'b1;
		axi_read(`OFS_CTRL, rd, resp);
		check(rd, rows[0].rexp);
		axi_read(`OFS_REF_EN, rd, resp);
		check(rd, rows[1].rexp);
		complete_run;
	end
endmodule
